// ### capcom_pkg.sv
// Purpose: shared constants for the capture/compare mode and hall sync block
// Assumes: 32-bit classic wishbone register port, word aligned registers
// Notes:   all offsets are byte addresses
package capcom_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] MODE_LOW_OFS   = 8'h00;
  localparam logic [7:0] MODE_HIGH_OFS  = 8'h04;
  localparam logic [7:0] SOFT_CTRL_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0C;
  localparam logic [7:0] MAIN_CAP0_OFS  = 8'h10;
  localparam logic [7:0] SHADOW_CAP0_OFS = 8'h1C;
  localparam logic [7:0] CAP_STRIDE     = 8'h04;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] MODE_LOW_RESET  = 8'h00;
  localparam logic [7:0] MODE_HIGH_RESET = 8'h00;
  localparam int         CH1_FIELD_LSB   = 4;
  localparam int         HSYNC_LSB       = 4;
  localparam int         HSYNC_MSB       = 6;
  localparam int         BYPASS_BIT      = 7;
  localparam int         SOFT_TRIG_BIT   = 0;
  localparam int         STATE_LSB       = 8;
  localparam logic [5:0] DTC_SAMPLE_VAL  = 6'h01;

  // ==========================================================
  // channel modes
  typedef enum logic [3:0] {
    MODE_OFF       = 4'h0,
    MODE_CMP_PIN   = 4'h1,
    MODE_CMP_COMP  = 4'h2,
    MODE_CMP_BOTH  = 4'h3,
    MODE_DBL_SPLIT = 4'h4,
    MODE_DBL_RISE  = 4'h5,
    MODE_DBL_FALL  = 4'h6,
    MODE_DBL_ANY   = 4'h7,
    MODE_HALL      = 4'h8,
    MODE_HYST      = 4'h9,
    MODE_MI_RF     = 4'hA,
    MODE_MI_FR     = 4'hB,
    MODE_MI_RR     = 4'hC,
    MODE_MI_FF     = 4'hD,
    MODE_MI_AA     = 4'hE,
    MODE_RESERVED  = 4'hF
  } chan_mode_type;

  // hall sampling sources
  typedef enum logic [2:0] {
    HS_POS_EDGE   = 3'h0,
    HS_AUX_CMP    = 3'h1,
    HS_AUX_PER    = 3'h2,
    HS_OFF        = 3'h3,
    HS_MAIN_PER   = 3'h4,
    HS_MAIN_ONE   = 3'h5,
    HS_CH0_UP     = 3'h6,
    HS_CH0_DOWN   = 3'h7
  } hall_src_type;

endpackage

// ### edge_bus_if.sv
// Purpose: carries synchronised levels and edge pulses between modules
// Assumes: single clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface edge_bus_if #(parameter int W = 6);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ### edge_sync.sv
// Purpose: two-stage synchroniser plus edge detector for input pins
// Assumes: one clock, synchronous active high reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // raw pins
  input  wire logic [W-1:0] pin_i,
  // edges out
  edge_bus_if.src           edges
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // ==========================================================
  // synchroniser and history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ==========================================================
  // edge pulses
  assign edges.lvl  = sync_r;
  assign edges.rise = sync_r & ~prev_r;
  assign edges.fall = ~sync_r & prev_r;

endmodule
`default_nettype wire

// ### timer_channel_mode_and_hall_sync.sv
// Purpose: mode selection, capture and hall sampling for three timer channels
// Assumes: classic wishbone slave, timer counter and dead-time counter outside
// Notes:   registers answer one cycle after a request
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - mode 0000: no compare drive on either pin, no capture
// - modes 0001/0010/0011 route compare to pin, complementary pin, or both
// - hall edge detection only when all three modes are 1000
// - mode 0100: rising edge captures main, falling edge captures shadow
// - modes 0101-0111: shadow to main, timer to shadow, on rise/fall/any
// - hall mode: channel 0 captures, channels 1 and 2 drive no pins and capture nothing
// - hall mode: valid hall event captures timer in channel 0, then resets timer
// - hall mode: hall edge starts dead-time counter, sample at value 000001
// - mode 1001: position fall clears state bit; compare event sets it if high
// - modes 1010/1011: pin rise/fall to main, opposite position edge to shadow
// - modes 1100-1110: pin edge to main, position edge to shadow
// - mode 1111 reserved: no capture, no compare
// - sampling source 000 pos edge, 001 aux cmp, 010 aux period, 011 off
// - source 100 period up, 101 one down, 110/111 channel 0 match up/down
// - soft hall trigger always samples and compares
// - bypass bit 0 delays sampling through dead-time counter 0
// - capture modes: every capture pin edge sets its status flag
// - multi-input: selected position event sets state bit; software clears
// - channels 0/1 modes in bits 3:0 and 7:4 of low register
// - capture pin rise sets rise flag, fall sets fall flag
module timer_channel_mode_and_hall_sync
  import capcom_pkg::*;
#(
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // pins
  input  wire logic [2:0]    channel_pin_i,
  input  wire logic [2:0]    position_input_i,
  output logic      [2:0]    channel_pin_o,
  output logic      [2:0]    channel_pin_oe_n_o,
  output logic      [2:0]    complementary_pin_o,
  output logic      [2:0]    complementary_pin_oe_n_o,
  // main and aux timers
  input  wire logic [TW-1:0] main_timer_value_i,
  input  wire logic          main_timer_count_down_i,
  input  wire logic          main_period_match_i,
  input  wire logic          main_one_match_i,
  input  wire logic          ch0_compare_match_i,
  input  wire logic          aux_compare_match_i,
  input  wire logic          aux_period_match_i,
  input  wire logic [2:0]    compare_out_i,
  input  wire logic [2:0]    compare_event_i,
  output logic               main_timer_reset_o,
  // dead-time counter zero
  input  wire logic [5:0]    deadtime_counter_zero_i,
  output logic               deadtime_start_o,
  // hall pattern logic
  input  wire logic          hall_valid_event_i,
  output logic               hall_edge_en_o,
  output logic               hall_sample_o,
  output logic      [2:0]    hall_pattern_o,
  output logic      [2:0]    channel_state_bit_o
);

  // ==========================================================
  // declarations
  edge_bus_if #(.W(6)) edges ();

  logic [7:0]    mode_low_r;
  logic [7:0]    mode_high_r;
  logic [5:0]    irq_status_r;
  logic [2:0]    state_r;
  logic [TW-1:0] main_cap_r [3];
  logic [TW-1:0] shadow_cap_r [3];
  logic [3:0]    mode [3];
  logic [2:0]    cp_rise;
  logic [2:0]    cp_fall;
  logic [2:0]    pos_rise;
  logic [2:0]    pos_fall;
  logic [2:0]    pos_lvl;
  logic          hall_mode;
  logic          hw_trig;
  logic          dtc_start;
  logic          dtc_wait_r;
  logic          sample_nxt;
  logic          soft_trig;
  logic          wr_go;
  logic          rd_go;
  logic [2:0]    pos_sel;
  logic          timer_reset_r;
  logic          hall_sample_r;
  logic [2:0]    hall_pattern_r;
  logic [31:0]   rd_data;

  // ==========================================================
  // decode helpers
  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m inside {MODE_DBL_SPLIT, MODE_DBL_RISE, MODE_DBL_FALL, MODE_DBL_ANY})
              || (m inside {MODE_MI_RF, MODE_MI_FR, MODE_MI_RR, MODE_MI_FF, MODE_MI_AA});
  endfunction

  function automatic logic drives_pin(input logic [3:0] m);
    drives_pin = m inside {MODE_CMP_PIN, MODE_CMP_BOTH, MODE_HYST};
  endfunction

  function automatic logic drives_comp(input logic [3:0] m);
    drives_comp = m inside {MODE_CMP_COMP, MODE_CMP_BOTH, MODE_HYST};
  endfunction

  // ==========================================================
  // input synchronisers
  edge_sync #(.W(6)) u_edges (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({position_input_i, channel_pin_i}),
    .edges (edges)
  );

  assign cp_rise  = edges.rise[2:0];
  assign cp_fall  = edges.fall[2:0];
  assign pos_rise = edges.rise[5:3];
  assign pos_fall = edges.fall[5:3];
  assign pos_lvl  = edges.lvl[5:3];

  assign mode[0] = mode_low_r[3:0];
  assign mode[1] = mode_low_r[CH1_FIELD_LSB +: 4];
  assign mode[2] = mode_high_r[3:0];

  // ==========================================================
  // wishbone slave
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign soft_trig = wr_go && (wb_adr_i == SOFT_CTRL_OFS) && wb_sel_i[0]
                     && wb_dat_i[SOFT_TRIG_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      MODE_LOW_OFS:  rd_data[7:0] = mode_low_r;
      MODE_HIGH_OFS: rd_data[7:0] = mode_high_r;
      STATUS_OFS:    rd_data = {21'h000000, state_r, 2'h0, irq_status_r};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (wb_adr_i == MAIN_CAP0_OFS + 8'(i) * CAP_STRIDE) begin
            rd_data[TW-1:0] = main_cap_r[i];
          end
          if (wb_adr_i == SHADOW_CAP0_OFS + 8'(i) * CAP_STRIDE) begin
            rd_data[TW-1:0] = shadow_cap_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_go) begin
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_low_r  <= MODE_LOW_RESET;
      mode_high_r <= MODE_HIGH_RESET;
    end else if (wr_go && wb_sel_i[0]) begin
      if (wb_adr_i == MODE_LOW_OFS) begin
        mode_low_r <= wb_dat_i[7:0];
      end
      if (wb_adr_i == MODE_HIGH_OFS) begin
        mode_high_r <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // status flags and state bits
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [2:0] state_set;
  logic [2:0] state_clr;

  always_comb begin
    flag_set  = 6'h00;
    state_set = 3'h0;
    state_clr = 3'h0;
    pos_sel   = 3'h0;
    for (int n = 0; n < 3; n++) begin
      if (is_capture(mode[n])) begin
        flag_set[2*n]   = cp_rise[n];
        flag_set[2*n+1] = cp_fall[n];
      end
      unique case (mode[n])
        MODE_MI_RF: pos_sel[n] = pos_fall[n];
        MODE_MI_FR: pos_sel[n] = pos_rise[n];
        MODE_MI_RR: pos_sel[n] = pos_rise[n];
        MODE_MI_FF: pos_sel[n] = pos_fall[n];
        MODE_MI_AA: pos_sel[n] = pos_rise[n] | pos_fall[n];
        default:    pos_sel[n] = 1'b0;
      endcase
      state_set[n] = pos_sel[n];
      if (mode[n] == MODE_HYST) begin
        state_clr[n] = pos_fall[n];
        state_set[n] = compare_event_i[n] && pos_lvl[n];
      end
    end
  end

  assign flag_clr = (wr_go && (wb_adr_i == STATUS_OFS) && wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= 6'h00;
    end else begin
      irq_status_r <= (irq_status_r & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= 3'h0;
    end else begin
      state_r <= (state_r & ~state_clr & ~((wr_go && (wb_adr_i == STATUS_OFS) && wb_sel_i[1])
                 ? wb_dat_i[STATE_LSB +: 3] : 3'h0)) | state_set;
    end
  end

  assign channel_state_bit_o = state_r;

  // ==========================================================
  // capture registers
  for (genvar n = 0; n < 3; n++) begin : g_cap
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        main_cap_r[n]   <= '0;
        shadow_cap_r[n] <= '0;
      end else begin
        unique case (mode[n])
          MODE_DBL_SPLIT: begin
            if (cp_rise[n]) main_cap_r[n] <= main_timer_value_i;
            if (cp_fall[n]) shadow_cap_r[n] <= main_timer_value_i;
          end
          MODE_DBL_RISE, MODE_DBL_FALL, MODE_DBL_ANY: begin
            if ((mode[n] == MODE_DBL_RISE && cp_rise[n])
                || (mode[n] == MODE_DBL_FALL && cp_fall[n])
                || (mode[n] == MODE_DBL_ANY && (cp_rise[n] || cp_fall[n]))) begin
              main_cap_r[n]   <= shadow_cap_r[n];
              shadow_cap_r[n] <= main_timer_value_i;
            end
          end
          MODE_HALL: begin
            if (n == 0 && hall_mode && hall_valid_event_i) begin
              main_cap_r[n] <= main_timer_value_i;
            end
          end
          MODE_MI_RF, MODE_MI_RR: begin
            if (cp_rise[n]) main_cap_r[n] <= main_timer_value_i;
            if (pos_sel[n]) shadow_cap_r[n] <= main_timer_value_i;
          end
          MODE_MI_FR, MODE_MI_FF: begin
            if (cp_fall[n]) main_cap_r[n] <= main_timer_value_i;
            if (pos_sel[n]) shadow_cap_r[n] <= main_timer_value_i;
          end
          MODE_MI_AA: begin
            if (cp_rise[n] || cp_fall[n]) main_cap_r[n] <= main_timer_value_i;
            if (pos_sel[n]) shadow_cap_r[n] <= main_timer_value_i;
          end
          default: begin
          end
        endcase
      end
    end

    // compare output routing
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        channel_pin_o[n]            <= 1'b0;
        complementary_pin_o[n]      <= 1'b0;
        channel_pin_oe_n_o[n]       <= 1'b1;
        complementary_pin_oe_n_o[n] <= 1'b1;
      end else begin
        channel_pin_oe_n_o[n]       <= !drives_pin(mode[n]);
        complementary_pin_oe_n_o[n] <= !drives_comp(mode[n]);
        channel_pin_o[n]       <= drives_pin(mode[n]) && compare_out_i[n]
                                  && (mode[n] != MODE_HYST || state_r[n]);
        complementary_pin_o[n] <= drives_comp(mode[n]) && !compare_out_i[n]
                                  && (mode[n] != MODE_HYST || state_r[n]);
      end
    end
  end

  // ==========================================================
  // hall sampling trigger
  assign hall_mode = (mode[0] == MODE_HALL) && (mode[1] == MODE_HALL)
                     && (mode[2] == MODE_HALL);
  assign hall_edge_en_o = hall_mode;

  always_comb begin
    unique case (hall_src_type'(mode_high_r[HSYNC_MSB:HSYNC_LSB]))
      HS_POS_EDGE: hw_trig = |(pos_rise | pos_fall);
      HS_AUX_CMP:  hw_trig = aux_compare_match_i;
      HS_AUX_PER:  hw_trig = aux_period_match_i;
      HS_OFF:      hw_trig = 1'b0;
      HS_MAIN_PER: hw_trig = main_period_match_i && !main_timer_count_down_i;
      HS_MAIN_ONE: hw_trig = main_one_match_i && main_timer_count_down_i;
      HS_CH0_UP:   hw_trig = ch0_compare_match_i && !main_timer_count_down_i;
      HS_CH0_DOWN: hw_trig = ch0_compare_match_i && main_timer_count_down_i;
    endcase
  end

  // delayed path starts the dead-time counter, position edges do in hall mode
  assign dtc_start = (hw_trig && !mode_high_r[BYPASS_BIT])
                     || (hall_mode && |(pos_rise | pos_fall));
  assign deadtime_start_o = dtc_start;

  assign sample_nxt = soft_trig
                      || (hw_trig && mode_high_r[BYPASS_BIT])
                      || (dtc_wait_r && !dtc_start
                          && deadtime_counter_zero_i == DTC_SAMPLE_VAL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtc_wait_r <= 1'b0;
    end else if (dtc_start) begin
      dtc_wait_r <= 1'b1;
    end else if (deadtime_counter_zero_i == DTC_SAMPLE_VAL) begin
      dtc_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hall_sample_r  <= 1'b0;
      hall_pattern_r <= 3'h0;
    end else begin
      hall_sample_r <= sample_nxt;
      if (sample_nxt) begin
        hall_pattern_r <= pos_lvl;
      end
    end
  end

  assign hall_sample_o  = hall_sample_r;
  assign hall_pattern_o = hall_pattern_r;

  // timer reset is registered and rises on the same edge that loads the channel 0 capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_reset_r <= 1'b0;
    end else begin
      timer_reset_r <= hall_mode && hall_valid_event_i;
    end
  end

  assign main_timer_reset_o = timer_reset_r;

endmodule
`default_nettype wire

// ### timer_channel_mode_and_hall_sync_sva.sv
// Purpose: port checks for the mode and hall sync block
// Assumes: bound to the top module, one clock
// Notes:   mode registers mirrored from bus writes
`timescale 1ns/1ns
`default_nettype none
module capcom_sva
  import capcom_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  // pins and timers
  input wire logic [2:0]  channel_pin_oe_n_o,
  input wire logic [2:0]  complementary_pin_oe_n_o,
  input wire logic        main_timer_count_down_i,
  input wire logic        main_period_match_i,
  input wire logic        main_one_match_i,
  input wire logic        ch0_compare_match_i,
  input wire logic        aux_compare_match_i,
  input wire logic        aux_period_match_i,
  input wire logic        main_timer_reset_o,
  input wire logic [5:0]  deadtime_counter_zero_i,
  input wire logic        deadtime_start_o,
  input wire logic        hall_valid_event_i,
  input wire logic        hall_edge_en_o,
  input wire logic        hall_sample_o
);
  // ====
  // mirrored state
  logic [7:0] mode_lo_r, mode_hi_r;
  logic       wait_r, src_hit, wr, byp;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign byp = mode_hi_r[BYPASS_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_lo_r <= 8'h00;
      mode_hi_r <= 8'h00;
    end else if (wr && wb_adr_i == MODE_LOW_OFS) begin
      mode_lo_r <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == MODE_HIGH_OFS) begin
      mode_hi_r <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || deadtime_counter_zero_i == DTC_SAMPLE_VAL) begin
      wait_r <= 1'b0;
    end else if (deadtime_start_o) begin
      wait_r <= 1'b1;
    end
  end
  always_comb begin
    case (hall_src_type'(mode_hi_r[6:4]))
      HS_AUX_CMP:  src_hit = aux_compare_match_i;
      HS_AUX_PER:  src_hit = aux_period_match_i;
      HS_MAIN_PER: src_hit = main_period_match_i && !main_timer_count_down_i;
      HS_MAIN_ONE: src_hit = main_one_match_i && main_timer_count_down_i;
      HS_CH0_UP:   src_hit = ch0_compare_match_i && !main_timer_count_down_i;
      HS_CH0_DOWN: src_hit = ch0_compare_match_i && main_timer_count_down_i;
      default:     src_hit = 1'b0;
    endcase
  end
  // ====
  // assertions
  bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  hall_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hall_edge_en_o == (mode_lo_r == 8'h88 && mode_hi_r[3:0] == 4'h8)) else $error("hall en");
  pins_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_lo_r[3:0] inside {4'h0, 4'hF} |=> channel_pin_oe_n_o[0] && complementary_pin_oe_n_o[0])
    else $error("pin driven while off");
  pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_lo_r[3:0] inside {4'h1, 4'h2, 4'h3} |=> channel_pin_oe_n_o[0] == !$past(mode_lo_r[0])
    && complementary_pin_oe_n_o[0] == !$past(mode_lo_r[1])) else $error("bad routing");
  timer_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hall_edge_en_o && hall_valid_event_i |=> main_timer_reset_o) else $error("no timer reset");
  src_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
    byp && src_hit |=> hall_sample_o) else $error("no sample");
  src_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !byp && src_hit |-> deadtime_start_o) else $error("no delay start");
  delay_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_r && !byp && !deadtime_start_o && deadtime_counter_zero_i == DTC_SAMPLE_VAL
    |=> hall_sample_o) else $error("no delayed sample");
  soft_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == SOFT_CTRL_OFS && wb_dat_i[SOFT_TRIG_BIT] |=> hall_sample_o)
    else $error("no soft sample");
endmodule
bind timer_channel_mode_and_hall_sync capcom_sva capcom_sva_inst (.*);
`default_nettype wire

// ### sensor_model.sv
// Purpose: capture pins and hall position sensors
// Assumes: levels change just after a rising edge
// Notes:   each level is held long enough for a clean edge
`timescale 1ns/1ns
`default_nettype none
module sensor_model (
  // clock
  input  wire logic      clk_i,
  // pins toward the block
  output var  logic [2:0] channel_pin_o,
  output var  logic [2:0] position_input_o
);
  initial begin
    channel_pin_o = 3'h0;
    position_input_o = 3'h0;
  end
  // new levels, then hold well past the three-cycle minimum
  task automatic drive(input logic [2:0] pin, input logic [2:0] pos);
    @(posedge clk_i);
    channel_pin_o <= pin;
    position_input_o <= pos;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: scenario bench for the mode and hall sync block
// Assumes: 10 MHz clock, registers answer after one cycle
// Notes:   timer and dead-time values driven by the bench
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import capcom_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, down = 0, hv = 0, co = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdo;
  logic [3:0] sel = 4'hF;
  logic [5:0] ev = 6'h00;
  logic [15:0] tval = 16'h0000;
  logic [5:0] dtc = 6'h00;
  logic [2:0] pin, pos, poe, coe, pat, cst, cpo, cpc;
  logic ack, trst, dts, hen, hs;
  int errors = 0, checks = 0;
  always #50 clk_i = ~clk_i;
  sensor_model sensor_model_inst (.clk_i(clk_i), .channel_pin_o(pin), .position_input_o(pos));
  timer_channel_mode_and_hall_sync timer_channel_mode_and_hall_sync_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdo), .wb_ack_o(ack),
    .channel_pin_i(pin), .position_input_i(pos), .channel_pin_o(cpo),
    .channel_pin_oe_n_o(poe), .complementary_pin_o(cpc), .complementary_pin_oe_n_o(coe),
    .main_timer_value_i(tval), .main_timer_count_down_i(down), .main_period_match_i(ev[0]),
    .main_one_match_i(ev[1]), .ch0_compare_match_i(ev[2]), .aux_compare_match_i(ev[3]),
    .aux_period_match_i(ev[4]), .compare_out_i({2'b00, co}),
    .compare_event_i({2'b00, ev[5]}), .main_timer_reset_o(trst),
    .deadtime_counter_zero_i(dtc), .deadtime_start_o(dts),
    .hall_valid_event_i(hv), .hall_edge_en_o(hen), .hall_sample_o(hs),
    .hall_pattern_o(pat), .channel_state_bit_o(cst));
  // ====
  // shared tasks
  task automatic close_out();
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask
  // ====
  // scenarios
  task automatic t_regs();
    rd(MODE_LOW_OFS, 32'h0);
    rd(MODE_HIGH_OFS, 32'h0);
    wr(8'h30, 32'hFF);
    rd(8'h30, 32'h0);
    wr(MODE_LOW_OFS, 32'hA5);
    rd(MODE_LOW_OFS, 32'hA5);
    wr(MODE_HIGH_OFS, 32'hFFFFFFFF);
    rd(MODE_HIGH_OFS, 32'hFF);
  endtask
  task automatic t_quiet();
    logic [3:0] mt[5] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h3};
    logic [1:0] oe[5] = '{2'b11, 2'b11, 2'b01, 2'b10, 2'b00};
    for (int i = 0; i < 5; i++) begin
      wr(MODE_LOW_OFS, {28'h0, mt[i]});
      tval <= 16'h0F0F;
      sensor_model_inst.drive(3'h1, 3'h1);
      sensor_model_inst.drive(3'h0, 3'h0);
      chk(32'({poe[0], coe[0]}), 32'(oe[i]));
      rd(STATUS_OFS, 32'h0);
      rd(MAIN_CAP0_OFS, 32'h0);
    end
  endtask
  task automatic t_split();
    wr(MODE_LOW_OFS, 32'h04);
    tval <= 16'h1234;
    sensor_model_inst.drive(3'h1, 3'h0);
    tval <= 16'h2345;
    sensor_model_inst.drive(3'h0, 3'h0);
    rd(MAIN_CAP0_OFS, 32'h1234);
    rd(SHADOW_CAP0_OFS, 32'h2345);
    rd(STATUS_OFS, 32'h3);
    wr(STATUS_OFS, 32'h7FF);
    rd(STATUS_OFS, 32'h0);
  endtask
  task automatic t_chain();
    wr(MODE_LOW_OFS, 32'h50);
    tval <= 16'h0AAA;
    sensor_model_inst.drive(3'h2, 3'h0);
    tval <= 16'h0BBB;
    sensor_model_inst.drive(3'h0, 3'h0);
    tval <= 16'h0CCC;
    sensor_model_inst.drive(3'h2, 3'h0);
    rd(MAIN_CAP0_OFS + CAP_STRIDE, 32'h0AAA);
    rd(SHADOW_CAP0_OFS + CAP_STRIDE, 32'h0CCC);
    rd(STATUS_OFS, 32'h0C);
    sensor_model_inst.drive(3'h0, 3'h0);
    wr(STATUS_OFS, 32'h7FF);
  endtask
  task automatic t_multi();
    wr(MODE_HIGH_OFS, 32'h0C);
    wr(MODE_LOW_OFS, 32'hA0);
    tval <= 16'h0111;
    sensor_model_inst.drive(3'h6, 3'h0);
    tval <= 16'h0222;
    sensor_model_inst.drive(3'h6, 3'h6);
    rd(MAIN_CAP0_OFS + CAP_STRIDE, 32'h0111);
    rd(SHADOW_CAP0_OFS + CAP_STRIDE, 32'h0CCC);
    rd(MAIN_CAP0_OFS + 8'h08, 32'h0111);
    rd(SHADOW_CAP0_OFS + 8'h08, 32'h0222);
    rd(STATUS_OFS, 32'h414);
    sensor_model_inst.drive(3'h0, 3'h0);
    wr(STATUS_OFS, 32'h7FF);
    wr(MODE_HIGH_OFS, 32'h0);
  endtask
  task automatic t_hyst();
    wr(MODE_LOW_OFS, 32'h09);
    co <= 1'b1;
    sensor_model_inst.drive(3'h0, 3'h1);
    chk(32'({cst[0], cpo[0], cpc[0], poe[0], coe[0]}), 32'h00);
    pulse(5);
    repeat (2) @(posedge clk_i);
    chk(32'({cst[0], cpo[0], cpc[0], poe[0], coe[0]}), 32'h18);
    sensor_model_inst.drive(3'h0, 3'h0);
    chk(32'({cst[0], cpo[0], cpc[0], poe[0], coe[0]}), 32'h00);
  endtask
  task automatic t_sources();
    logic [2:0] sr[6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    int ix[6] = '{3, 4, 0, 1, 2, 2};
    logic [5:0] dn = 6'b101000;
    for (int i = 0; i < 6; i++) begin
      wr(MODE_HIGH_OFS, {24'h0, 1'b1, sr[i], 4'h0});
      down <= dn[i];
      pulse(ix[i]);
      @(posedge clk_i);
      chk(32'(hs), 32'h1);
    end
    wr(MODE_HIGH_OFS, 32'hB0);
    pulse(3);
    @(posedge clk_i);
    chk(32'(hs), 32'h0);
  endtask
  task automatic t_delay();
    wr(MODE_HIGH_OFS, 32'h10);
    @(posedge clk_i);
    ev[3] <= 1'b1;
    @(negedge clk_i);
    chk(32'(dts), 32'h1);
    @(posedge clk_i);
    ev[3] <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(hs), 32'h0);
    dtc <= DTC_SAMPLE_VAL;
    @(posedge clk_i);
    dtc <= 6'h00;
    @(posedge clk_i);
    chk(32'(hs), 32'h1);
  endtask
  task automatic t_hall();
    wr(MODE_LOW_OFS, 32'h88);
    @(negedge clk_i);
    chk(32'(hen), 32'h0);
    wr(MODE_HIGH_OFS, 32'hB8);
    @(negedge clk_i);
    chk(32'(hen), 32'h1);
    sensor_model_inst.drive(3'h0, 3'h5);
    wr(SOFT_CTRL_OFS, 32'h1);
    @(posedge clk_i);
    chk(32'(hs), 32'h1);
    chk(32'(pat), 32'h5);
    tval <= 16'h0777;
    @(posedge clk_i);
    hv <= 1'b1;
    @(posedge clk_i);
    hv <= 1'b0;
    @(posedge clk_i);
    chk(32'(trst), 32'h1);
    rd(MAIN_CAP0_OFS, 32'h0777);
  endtask
  initial begin
    #3000000;
    errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_quiet();
    t_split();
    t_chain();
    t_multi();
    t_hyst();
    t_sources();
    t_delay();
    t_hall();
    close_out();
  end
endmodule
`default_nettype wire
